// ===== core/io_space_pkg.sv
// io_space_pkg: shared constants and carrier types for the i/o space address decoder.
// assumes one cpu-side requester issuing one access at a time on sys_clk.
package io_space_pkg;

  localparam int unsigned DATA_W      = 8;          // i/o register width
  localparam int unsigned ADDR_W      = 16;         // cpu data-space address width
  localparam int unsigned GPR_COUNT   = 32;         // working registers below the i/o space
  localparam int unsigned IO_COUNT    = 64;         // locations in the in/out opcode field
  localparam int unsigned IO_FIELD_W  = 6;          // bits of that field
  localparam logic [ADDR_W-1:0] IO_LAST      = 16'h003f; // last in/out address
  localparam logic [ADDR_W-1:0] IO_BIT_LAST  = 16'h001f; // last bit-accessible address
  localparam logic [ADDR_W-1:0] IO_DATA_OFS  = 16'h0020; // i/o address to data address
  localparam logic [ADDR_W-1:0] EXT_FIRST    = 16'h0060; // extended i/o, load/store only
  localparam logic [ADDR_W-1:0] EXT_LAST     = 16'h01ff;
  localparam int unsigned MEM_DEPTH   = 480;        // 0x20..0x1ff held in storage
  localparam int unsigned MEM_AW      = 9;
  localparam logic [ADDR_W-1:0] FLAG_IO_ADDR = 16'h0016; // status flag register, i/o address
  localparam logic [DATA_W-1:0] FLAG_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO    = 8'h00;
  localparam logic [DATA_W-1:0] BIT0_MASK    = 8'h01;

  // instruction classes seen by the decoder; the direct and offset forms of a
  // memory access arrive as the same class since only the final address matters
  typedef enum logic [2:0] {
    IO_IN_OP,
    IO_OUT_OP,
    MEMORY_READ_OP,
    MEMORY_WRITE_OP,
    SET_IO_BIT_OP,
    CLEAR_IO_BIT_OP,
    SKIP_IF_IO_BIT_SET,
    SKIP_IF_IO_BIT_CLEAR
  } ioOp_t;

  typedef struct packed {
    logic              valid;
    ioOp_t             op;
    logic [ADDR_W-1:0] addr;    // i/o address for i/o classes, data address otherwise
    logic [2:0]        bitSel;
    logic [DATA_W-1:0] wdata;
  } ioReq_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
    logic              skip;
    logic              err;
  } ioRsp_t;

endpackage : io_space_pkg

// ===== core/io_reg_mem.sv
// io_reg_mem: byte storage for the i/o and extended i/o locations.
// assumes one write and one read port on the same clock; read data registered.
`timescale 1ns/1ps
`default_nettype none
module io_reg_mem #(
  parameter int unsigned DW    = 8,
  parameter int unsigned DEPTH = 480,
  parameter int unsigned AW    = 9
) (
  input  wire logic          sys_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] store [DEPTH];

  // no reset on the array: contents are undefined until software writes them
  always_ff @(posedge sys_clk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  // registered read keeps the array inferable as block memory
  always_ff @(posedge sys_clk) begin
    rdata_q <= store[raddr];
  end

endmodule : io_reg_mem
`default_nettype wire

// ===== core/io_space_address_decoder.sv
// io_space_address_decoder: decodes cpu i/o-space accesses onto register storage
// and one hardware status flag register.
// assumes the cpu holds req until reqReady and ignores rsp outside rsp.valid.
`timescale 1ns/1ps
`default_nettype none

module io_space_address_decoder
  import io_space_pkg::*;
#(
  parameter logic [ADDR_W-1:0] FLAG_ADDR = FLAG_IO_ADDR
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire ioReq_t            req,
  output logic                   reqReady,
  output ioRsp_t                 rsp,
  input  wire logic [DATA_W-1:0] flagSetHw,
  output logic      [DATA_W-1:0] flagState
);

  typedef enum logic {S_IDLE, S_EXEC} state_t;

  state_t            state_q;
  ioOp_t             op_q;
  logic [2:0]        bit_q;
  logic [DATA_W-1:0] wdata_q;
  logic              err_q;
  logic              isFlag_q;
  logic [MEM_AW-1:0] memAddr_q;
  logic [DATA_W-1:0] flags_q;
  ioRsp_t            rsp_q;

  logic              reqFire;
  logic              isIoClass;
  logic              isBitClass;
  logic              isMemClass;
  logic              decErr;
  logic [ADDR_W-1:0] dataAddr;
  logic [ADDR_W-1:0] memOfs;
  logic [MEM_AW-1:0] memRaddr;
  logic [DATA_W-1:0] memRd;
  logic [DATA_W-1:0] curByte;
  logic              curBit;
  logic [DATA_W-1:0] bitMask;
  logic              isWrite;
  logic              memWe;
  logic [DATA_W-1:0] memWdata;
  logic [DATA_W-1:0] flagClr;

  // one access in flight; the second cycle reads storage and writes back
  assign reqReady = (state_q == S_IDLE);
  assign reqFire  = req.valid && reqReady;

  // request decode
  always_comb begin
    isBitClass = (req.op == SET_IO_BIT_OP) || (req.op == CLEAR_IO_BIT_OP) ||
                 (req.op == SKIP_IF_IO_BIT_SET) || (req.op == SKIP_IF_IO_BIT_CLEAR);
    isIoClass  = (req.op == IO_IN_OP) || (req.op == IO_OUT_OP) || isBitClass;
    isMemClass = (req.op == MEMORY_READ_OP) || (req.op == MEMORY_WRITE_OP);
    dataAddr   = isIoClass ? (req.addr + IO_DATA_OFS) : req.addr;
    decErr     = 1'b0;
    if (isBitClass && (req.addr > IO_BIT_LAST)) begin
      decErr = 1'b1;
    end
    // in/out reach only the 64-entry field, never the extended region
    if (isIoClass && (req.addr > IO_LAST)) begin
      decErr = 1'b1;
    end
    // below 0x20 is the working register file, not this block
    if (isMemClass && ((req.addr < IO_DATA_OFS) || (req.addr > EXT_LAST))) begin
      decErr = 1'b1;
    end
  end

  assign memOfs   = dataAddr - IO_DATA_OFS;
  assign memRaddr = memOfs[MEM_AW-1:0];

  io_reg_mem #(
    .DW    (DATA_W),
    .DEPTH (MEM_DEPTH),
    .AW    (MEM_AW)
  ) u_mem (
    .sys_clk (sys_clk),
    .we      (memWe),
    .waddr   (memAddr_q),
    .wdata   (memWdata),
    .raddr   (memRaddr),
    .rdata_q (memRd)
  );

  // sequencing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
    end else if (reqFire) begin
      state_q <= S_EXEC;
    end else begin
      state_q <= S_IDLE;
    end
  end

  // capture the accepted request for the execute cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_q      <= IO_IN_OP;
      bit_q     <= 3'h0;
      wdata_q   <= BYTE_ZERO;
      err_q     <= 1'b0;
      isFlag_q  <= 1'b0;
      memAddr_q <= '0;
    end else if (reqFire) begin
      op_q      <= req.op;
      bit_q     <= req.bitSel;
      wdata_q   <= req.wdata;
      err_q     <= decErr;
      isFlag_q  <= (dataAddr == (FLAG_ADDR + IO_DATA_OFS));
      memAddr_q <= memRaddr;
    end
  end

  // execute-cycle data path
  always_comb begin
    bitMask  = BIT0_MASK << bit_q;
    curByte  = isFlag_q ? flags_q : memRd;
    curBit   = curByte[bit_q];
    isWrite  = (op_q == IO_OUT_OP) || (op_q == MEMORY_WRITE_OP) ||
               (op_q == SET_IO_BIT_OP) || (op_q == CLEAR_IO_BIT_OP);
    memWe    = (state_q == S_EXEC) && !err_q && !isFlag_q && isWrite;
    memWdata = wdata_q;
    flagClr  = BYTE_ZERO;
    unique case (op_q)
      SET_IO_BIT_OP:   memWdata = memRd | bitMask;
      CLEAR_IO_BIT_OP: memWdata = memRd & ~bitMask;
      default:         memWdata = wdata_q;
    endcase
    // a bit set on a flag writes one to that bit only; a bit clear writes zero,
    // so neighbouring flags survive either instruction
    if ((state_q == S_EXEC) && !err_q && isFlag_q) begin
      unique case (op_q)
        IO_OUT_OP, MEMORY_WRITE_OP: flagClr = wdata_q;
        SET_IO_BIT_OP:              flagClr = bitMask;
        default:                    flagClr = BYTE_ZERO;
      endcase
    end
  end

  // status flags: hardware set wins over a same-cycle write-one clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flags_q <= FLAG_RESET;
    end else begin
      flags_q <= (flags_q & ~flagClr) | flagSetHw;
    end
  end

  assign flagState = flags_q;

  // response, one cycle after execute
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= (state_q == S_EXEC);
      rsp_q.err   <= (state_q == S_EXEC) && err_q;
      rsp_q.data  <= BYTE_ZERO;
      rsp_q.skip  <= 1'b0;
      if ((state_q == S_EXEC) && !err_q) begin
        if ((op_q == IO_IN_OP) || (op_q == MEMORY_READ_OP)) begin
          rsp_q.data <= curByte;
        end
        if (op_q == SKIP_IF_IO_BIT_SET) begin
          rsp_q.skip <= curBit;
        end
        if (op_q == SKIP_IF_IO_BIT_CLEAR) begin
          rsp_q.skip <= !curBit;
        end
      end
    end
  end

  assign rsp = rsp_q;

  // checks
  property p_rsp_latency;
    @(posedge sys_clk) disable iff (!rst_n)
    reqFire |=> !reqReady ##1 (rsp.valid && reqReady);
  endproperty
  a_rsp_latency: assert property (p_rsp_latency)
    else $error("answer not two cycles after accept");

  property p_io_offset;
    @(posedge sys_clk) disable iff (!rst_n)
    (reqFire && (req.op == IO_IN_OP) && !decErr) |-> (memRaddr == req.addr[MEM_AW-1:0]);
  endproperty
  a_io_offset: assert property (p_io_offset) else $error("i/o to data offset wrong");

  property p_bit_range;
    @(posedge sys_clk) disable iff (!rst_n)
    (reqFire && isBitClass && (req.addr > IO_BIT_LAST)) |-> ##2 (rsp.valid && rsp.err);
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("bit access above 0x1f accepted");

  property p_io_field;
    @(posedge sys_clk) disable iff (!rst_n)
    (reqFire && (req.op == IO_OUT_OP) && (req.addr > IO_LAST)) |-> ##1 !memWe ##1 rsp.err;
  endproperty
  a_io_field: assert property (p_io_field) else $error("out beyond 64 locations wrote");

  property p_ext_region;
    @(posedge sys_clk) disable iff (!rst_n)
    (reqFire && isIoClass && !decErr) |-> (dataAddr < EXT_FIRST);
  endproperty
  a_ext_region: assert property (p_ext_region)
    else $error("i/o class reached extended region");

  property p_w1c;
    @(posedge sys_clk) disable iff (!rst_n)
    ((state_q == S_EXEC) && isFlag_q && !err_q && (op_q == MEMORY_WRITE_OP) && (flagSetHw == '0))
      |=> (flagState == ($past(flags_q) & ~$past(wdata_q)));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-to-clear misbehaved");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_n)
    (flagSetHw != '0) |=> ((flagState & $past(flagSetHw)) == $past(flagSetHw));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("hardware flag set lost");

  property p_single_bit;
    @(posedge sys_clk) disable iff (!rst_n)
    (memWe && ((op_q == SET_IO_BIT_OP) || (op_q == CLEAR_IO_BIT_OP)))
      |-> (((memWdata ^ memRd) & ~bitMask) == BYTE_ZERO);
  endproperty
  a_single_bit: assert property (p_single_bit) else $error("bit op changed other bits");

  property p_skip;
    @(posedge sys_clk) disable iff (!rst_n)
    ((state_q == S_EXEC) && !err_q && (op_q == SKIP_IF_IO_BIT_SET))
      |=> (rsp.skip == $past(curBit));
  endproperty
  a_skip: assert property (p_skip) else $error("skip result wrong");

endmodule : io_space_address_decoder
`default_nettype wire

// ===== tb/cpu_req_model.sv
// cpu_req_model: behavioural cpu core that issues one i/o access at a time.
// assumes callers enter access at a falling edge of sysClk.
`timescale 1ns/1ps
`default_nettype none
module cpu_req_model
  import io_space_pkg::*;
(
  input  wire logic   sysClk,
  input  wire logic   reqReady,
  input  wire ioRsp_t rsp,
  output var  ioReq_t req
);
  initial req = '0;

  // hold the request through the taking edge, answer is sampled two edges later;
  // callers keep reserved bits zero and aim no write at a reserved place
  task automatic access(input ioOp_t op, input logic [ADDR_W-1:0] a, input logic [2:0] b,
                        input logic [DATA_W-1:0] w, output ioRsp_t r);
    req <= '{valid: 1'b1, op: op, addr: a, bitSel: b, wdata: w};
    while (reqReady !== 1'b1) @(negedge sysClk);
    @(negedge sysClk);
    // released addr, bitSel and wdata flip so a stale value can never pass for a live one
    req <= '{valid: 1'b0, op: op, addr: ~a, bitSel: ~b, wdata: ~w};
    @(negedge sysClk);
    r = rsp;
  endtask : access
endmodule : cpu_req_model
`default_nettype wire

// ===== tb/tb.sv
// tb: self-checking bench for the i/o space address decoder.
// assumes cpu_req_model as the cpu side and a 20 mhz sys_clk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin numErrors++; \
  $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module tb;
  import io_space_pkg::*;
  typedef struct packed {
    ioOp_t       op;
    logic [15:0] a;
    logic [2:0]  b;
    logic [7:0]  w;
    logic [7:0]  d;
    logic        s;
    logic        e;
  } rowCase_t;

  // rows run in order: later reads depend on earlier writes
  localparam rowCase_t ROWS [23] = '{
    '{MEMORY_WRITE_OP, 16'h25, 3'h0, 8'ha5, 8'h00, 1'b0, 1'b0},
    '{IO_IN_OP, 16'h05, 3'h0, 8'h00, 8'ha5, 1'b0, 1'b0},
    '{IO_OUT_OP, 16'h3f, 3'h0, 8'h3c, 8'h00, 1'b0, 1'b0},
    '{MEMORY_READ_OP, 16'h5f, 3'h0, 8'h00, 8'h3c, 1'b0, 1'b0},
    '{IO_IN_OP, 16'h3f, 3'h0, 8'h00, 8'h3c, 1'b0, 1'b0},
    '{IO_OUT_OP, 16'h40, 3'h0, 8'h11, 8'h00, 1'b0, 1'b1},
    '{IO_IN_OP, 16'h60, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
    '{MEMORY_WRITE_OP, 16'h1ff, 3'h0, 8'h77, 8'h00, 1'b0, 1'b0},
    '{MEMORY_READ_OP, 16'h1ff, 3'h0, 8'h00, 8'h77, 1'b0, 1'b0},
    '{MEMORY_READ_OP, 16'h200, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
    '{MEMORY_WRITE_OP, 16'h1f, 3'h0, 8'h55, 8'h00, 1'b0, 1'b1},
    '{SET_IO_BIT_OP, 16'h05, 3'h6, 8'h00, 8'h00, 1'b0, 1'b0},
    '{IO_IN_OP, 16'h05, 3'h0, 8'h00, 8'he5, 1'b0, 1'b0},
    '{CLEAR_IO_BIT_OP, 16'h05, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0},
    '{MEMORY_READ_OP, 16'h25, 3'h0, 8'h00, 8'he4, 1'b0, 1'b0},
    '{SKIP_IF_IO_BIT_SET, 16'h05, 3'h2, 8'h00, 8'h00, 1'b1, 1'b0},
    '{SKIP_IF_IO_BIT_CLEAR, 16'h05, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0},
    '{SKIP_IF_IO_BIT_SET, 16'h05, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0},
    '{MEMORY_WRITE_OP, 16'h3f, 3'h0, 8'hff, 8'h00, 1'b0, 1'b0},
    '{CLEAR_IO_BIT_OP, 16'h1f, 3'h7, 8'h00, 8'h00, 1'b0, 1'b0},
    '{IO_IN_OP, 16'h1f, 3'h0, 8'h00, 8'h7f, 1'b0, 1'b0},
    '{SET_IO_BIT_OP, 16'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
    '{SKIP_IF_IO_BIT_CLEAR, 16'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1}
  };

  logic       sysClk;
  logic       rstN;
  ioReq_t     req;
  logic       reqReady;
  ioRsp_t     rsp;
  logic [7:0] flagSetHw;
  logic [7:0] flagState;
  ioRsp_t     r;
  ioRsp_t     expRsp;
  int         numErrors;
  int         checked;
  int         cycles;

  io_space_address_decoder dut (
    .sys_clk(sysClk), .rst_n(rstN), .req(req), .reqReady(reqReady), .rsp(rsp),
    .flagSetHw(flagSetHw), .flagState(flagState));
  cpu_req_model cpu (.sysClk(sysClk), .reqReady(reqReady), .rsp(rsp), .req(req));

  initial begin
    sysClk = 1'b0;
    forever #25 sysClk = ~sysClk;
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // a hang ends the run; the whole sequence needs about 80 cycles
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 1000) begin
      numErrors++;
      finish_test();
    end
  end

  // one pulse on the hardware flag inputs, seen on flagState one edge later
  task automatic pulse(input logic [7:0] v);
    flagSetHw <= v;
    @(negedge sysClk);
    flagSetHw <= 8'h00;
  endtask : pulse

  initial begin
    rstN = 1'b0;
    flagSetHw = 8'h00;
    repeat (16) @(negedge sysClk);
    `CHK({reqReady, rsp, flagState}, {1'b1, 11'h000, 8'h00})
    rstN <= 1'b1;
    foreach (ROWS[i]) begin
      cpu.access(ROWS[i].op, ROWS[i].a, ROWS[i].b, ROWS[i].w, r);
      expRsp = ioRsp_t'({1'b1, ROWS[i].d, ROWS[i].s, ROWS[i].e});
      `CHK(r, expRsp)
    end
    // status flags: write-one-to-clear and bit instructions
    pulse(8'h05);
    `CHK(flagState, 8'h05)
    cpu.access(IO_OUT_OP, 16'h16, 3'h0, 8'h01, r);
    `CHK(flagState, 8'h04)
    cpu.access(IO_OUT_OP, 16'h16, 3'h0, 8'h00, r);
    `CHK(flagState, 8'h04)
    pulse(8'h03);
    cpu.access(SET_IO_BIT_OP, 16'h16, 3'h1, 8'h00, r);
    `CHK(flagState, 8'h05)
    cpu.access(CLEAR_IO_BIT_OP, 16'h16, 3'h0, 8'h00, r);
    `CHK(flagState, 8'h05)
    cpu.access(IO_IN_OP, 16'h16, 3'h0, 8'h00, r);
    `CHK(r.data, 8'h05)
    cpu.access(MEMORY_WRITE_OP, 16'h36, 3'h0, 8'h04, r);
    `CHK(flagState, 8'h01)
    // hardware set held through a write-one clear of the same flag: set wins
    flagSetHw <= 8'h01;
    cpu.access(IO_OUT_OP, 16'h16, 3'h0, 8'h01, r);
    flagSetHw <= 8'h00;
    `CHK(flagState, 8'h01)
    // second reset in mid-run clears the flags again
    rstN <= 1'b0;
    repeat (2) @(negedge sysClk);
    `CHK({reqReady, rsp, flagState}, {1'b1, 11'h000, 8'h00})
    rstN <= 1'b1;
    // first cycle after release already takes a request
    cpu.access(IO_IN_OP, 16'h16, 3'h0, 8'h00, r);
    `CHK(r, ioRsp_t'({1'b1, 8'h00, 1'b0, 1'b0}))
    finish_test();
  end
endmodule : tb
`default_nettype wire
